/* src/mss_pkg.sv */
// Purpose: shared constants and types for the startup settings register
// Assumes: one aligned 32-bit word per register on an AXI4-Lite bus
// Notes: field positions and decode tables live here
package mss_pkg;

	// ----------------------------------------
	// register map
	// ----------------------------------------
	localparam logic [7:0] MSS_ADDR_STARTUP = 8'h84;
	localparam logic [7:0] MSS_ADDR_DECODED = 8'h88;
	localparam logic [31:0] MSS_RESET_STARTUP = 32'h0000_0000;
	localparam logic [1:0] MSS_RESP_OKAY = 2'b00;
	localparam logic [1:0] MSS_RESP_SLVERR = 2'b10;

	// ----------------------------------------
	// field positions
	// ----------------------------------------
	localparam int MSS_POS_PARITY = 31;
	localparam int MSS_POS_METHOD = 29;
	localparam int MSS_POS_RAMP = 25;
	localparam int MSS_POS_ALIGN_TIME = 21;
	localparam int MSS_POS_PHASE_CAP = 17;
	localparam int MSS_POS_PULSE_RATE = 14;
	localparam int MSS_POS_THRESHOLD = 9;
	localparam int MSS_POS_RELEASE = 8;
	localparam int MSS_POS_ADVANCE = 6;
	localparam int MSS_POS_REPEAT = 4;
	localparam int MSS_POS_CAP_SRC = 3;
	localparam int MSS_POS_RAMPDOWN = 2;
	localparam int MSS_POS_BRAKE = 1;
	localparam int MSS_POS_REVERSE = 0;

	// ----------------------------------------
	// decode limits
	// ----------------------------------------
	localparam logic [4:0] MSS_THRESHOLD_MAX_CODE = 5'h11;
	localparam logic [3:0] MSS_RAMP_UNLIMITED_CODE = 4'hf;
	localparam int MSS_ALIGN_TIME_BASE_MS = 10;
	localparam int MSS_CLK_HZ = 10000000;

	typedef enum logic [1:0] {
		MSS_START_ALIGN,
		MSS_START_DOUBLE_ALIGN,
		MSS_START_POSITION_DETECT,
		MSS_START_SLOW_CYCLE
	} mss_method_t;

	typedef struct packed {
		logic parity;
		mss_method_t start_method_sel;
		logic [3:0] current_ramp_rate;
		logic [3:0] align_time;
		logic [3:0] start_phase_current_cap;
		logic [2:0] position_probe_pulse_rate;
		logic [4:0] position_probe_current_threshold;
		logic position_probe_release_sel;
		logic [1:0] position_probe_advance;
		logic [1:0] position_probe_repeat_count;
		logic open_loop_cap_source_sel;
		logic torque_current_rampdown_en;
		logic active_brake_en;
		logic reverse_param_source_sel;
	} mss_fields_t;

	typedef struct packed {
		logic single_align;
		logic double_align;
		logic position_detect;
		logic slow_cycle;
		logic ramp_unlimited;
		logic [2:0] probe_runs_minus1;
		logic threshold_valid;
		logic tristate_release;
		logic use_general_cap;
		logic use_reverse_params;
		logic rampdown_en;
		logic brake_en;
		logic [6:0] advance_deg;
		logic [13:0] probe_rate_hz;
		logic [13:0] align_time_ms;
	} mss_ctrl_t;

	// align time per code, ms
	localparam logic [13:0] MSS_ALIGN_MS [16] = '{
		14'd10, 14'd50, 14'd100, 14'd200, 14'd300, 14'd400, 14'd500, 14'd750,
		14'd1000, 14'd1500, 14'd2000, 14'd3000, 14'd4000, 14'd5000, 14'd7500, 14'd10000};
	// probe pulse rate per code, Hz
	localparam logic [13:0] MSS_PROBE_HZ [8] = '{
		14'd50, 14'd100, 14'd250, 14'd500, 14'd1000, 14'd2000, 14'd5000, 14'd10000};

endpackage : mss_pkg

/* src/mss_decode.sv */
// Purpose: turns raw field codes into control levels
// Assumes: purely combinational
// Notes: outputs are registered by the top
`timescale 1ns/1ps
`default_nettype none
module mss_decode
	import mss_pkg::*;
(
	input wire mss_fields_t fields,
	output mss_ctrl_t ctrl
);

	always_comb begin
		ctrl = '0;
		case (fields.start_method_sel)
			MSS_START_ALIGN: ctrl.single_align = 1'b1;
			MSS_START_DOUBLE_ALIGN: ctrl.double_align = 1'b1;
			MSS_START_POSITION_DETECT: ctrl.position_detect = 1'b1;
			MSS_START_SLOW_CYCLE: ctrl.slow_cycle = 1'b1;
			default: ctrl.single_align = 1'b1;
		endcase
		ctrl.ramp_unlimited = (fields.current_ramp_rate == MSS_RAMP_UNLIMITED_CODE);
		ctrl.align_time_ms = MSS_ALIGN_MS[fields.align_time];
		ctrl.probe_rate_hz = MSS_PROBE_HZ[fields.position_probe_pulse_rate];
		ctrl.threshold_valid = (fields.position_probe_current_threshold <= MSS_THRESHOLD_MAX_CODE);
		ctrl.tristate_release = fields.position_probe_release_sel;
		ctrl.advance_deg = 7'(30 * fields.position_probe_advance);
		ctrl.probe_runs_minus1 = {1'b0, fields.position_probe_repeat_count};
		ctrl.use_general_cap = fields.open_loop_cap_source_sel;
		ctrl.rampdown_en = fields.torque_current_rampdown_en;
		ctrl.brake_en = fields.active_brake_en;
		ctrl.use_reverse_params = fields.reverse_param_source_sel;
	end

endmodule : mss_decode
`default_nettype wire

/* src/mss_axil_slave.sv */
// Purpose: AXI4-Lite slave front end, single outstanding write and read
// Assumes: aw and w may arrive in either order
// Notes: reports a write strobe and a read address to the top
`timescale 1ns/1ps
`default_nettype none
module mss_axil_slave
	import mss_pkg::*;
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [7:0] s_awaddr,
	input wire logic s_awvalid,
	output logic s_awready,
	input wire logic [31:0] s_wdata,
	input wire logic [3:0] s_wstrb,
	input wire logic s_wvalid,
	output logic s_wready,
	output logic [1:0] s_bresp,
	output logic s_bvalid,
	input wire logic s_bready,
	input wire logic [7:0] s_araddr,
	input wire logic s_arvalid,
	output logic s_arready,
	output logic [31:0] s_rdata,
	output logic [1:0] s_rresp,
	output logic s_rvalid,
	input wire logic s_rready,
	output logic wr_en,
	output logic [7:0] wr_addr,
	output logic [31:0] wr_data,
	output logic [3:0] wr_strb,
	input wire logic wr_ok,
	output logic [7:0] rd_addr,
	input wire logic [31:0] rd_data,
	input wire logic rd_ok
);

	logic aw_have_q;
	logic w_have_q;
	logic wr_fire;

	// ----------------------------------------
	// write channel
	// ----------------------------------------
	// readies are flops: low while a beat is held or a response waits
	assign wr_fire = aw_have_q && w_have_q && !s_bvalid;
	assign wr_en = wr_fire;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_have_q <= 1'b0;
			w_have_q <= 1'b0;
			s_awready <= 1'b1;
			s_wready <= 1'b1;
			wr_addr <= '0;
			wr_data <= '0;
			wr_strb <= '0;
			s_bvalid <= 1'b0;
			s_bresp <= MSS_RESP_OKAY;
		end else begin
			if (s_awvalid && s_awready) begin
				aw_have_q <= 1'b1;
				s_awready <= 1'b0;
				wr_addr <= s_awaddr;
			end
			if (s_wvalid && s_wready) begin
				w_have_q <= 1'b1;
				s_wready <= 1'b0;
				wr_data <= s_wdata;
				wr_strb <= s_wstrb;
			end
			if (wr_fire) begin
				aw_have_q <= 1'b0;
				w_have_q <= 1'b0;
				s_bvalid <= 1'b1;
				s_bresp <= wr_ok ? MSS_RESP_OKAY : MSS_RESP_SLVERR;
			end else if (s_bvalid && s_bready) begin
				s_bvalid <= 1'b0;
				s_awready <= 1'b1;
				s_wready <= 1'b1;
			end
		end
	end

	// ----------------------------------------
	// read channel
	// ----------------------------------------
	assign rd_addr = s_araddr;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_rvalid <= 1'b0;
			s_arready <= 1'b1;
			s_rdata <= '0;
			s_rresp <= MSS_RESP_OKAY;
		end else if (s_arvalid && s_arready) begin
			s_rvalid <= 1'b1;
			s_arready <= 1'b0;
			s_rdata <= rd_ok ? rd_data : 32'h0000_0000;
			s_rresp <= rd_ok ? MSS_RESP_OKAY : MSS_RESP_SLVERR;
		end else if (s_rvalid && s_rready) begin
			s_rvalid <= 1'b0;
			s_arready <= 1'b1;
		end
	end

endmodule : mss_axil_slave
`default_nettype wire

/* src/mss_startup_regs.sv */
// Purpose: motor startup settings register with decoded control outputs
// Assumes: single clock aclk, synchronous active-low reset
// Notes: second word reads back decoded state
//
// Chosen here: the register offsets and the AXI4-Lite register port.
`timescale 1ns/1ps
`default_nettype none

module mss_startup_regs
	import mss_pkg::*;
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [7:0] s_awaddr,
	input wire logic s_awvalid,
	output logic s_awready,
	input wire logic [31:0] s_wdata,
	input wire logic [3:0] s_wstrb,
	input wire logic s_wvalid,
	output logic s_wready,
	output logic [1:0] s_bresp,
	output logic s_bvalid,
	input wire logic s_bready,
	input wire logic [7:0] s_araddr,
	input wire logic s_arvalid,
	output logic s_arready,
	output logic [31:0] s_rdata,
	output logic [1:0] s_rresp,
	output logic s_rvalid,
	input wire logic s_rready,
	output mss_fields_t fields_q,
	output mss_ctrl_t ctrl_q
);

	logic wr_en;
	logic [7:0] wr_addr;
	logic [31:0] wr_data;
	logic [3:0] wr_strb;
	logic wr_ok;
	logic [7:0] rd_addr;
	logic [31:0] rd_data;
	logic rd_ok;
	logic [31:0] reg_q;
	logic [31:0] reg_d;
	mss_ctrl_t ctrl_d;

	// ----------------------------------------
	// bus front end
	// ----------------------------------------
	mss_axil_slave u_bus (
		.aclk(aclk),
		.aresetn(aresetn),
		.s_awaddr(s_awaddr),
		.s_awvalid(s_awvalid),
		.s_awready(s_awready),
		.s_wdata(s_wdata),
		.s_wstrb(s_wstrb),
		.s_wvalid(s_wvalid),
		.s_wready(s_wready),
		.s_bresp(s_bresp),
		.s_bvalid(s_bvalid),
		.s_bready(s_bready),
		.s_araddr(s_araddr),
		.s_arvalid(s_arvalid),
		.s_arready(s_arready),
		.s_rdata(s_rdata),
		.s_rresp(s_rresp),
		.s_rvalid(s_rvalid),
		.s_rready(s_rready),
		.wr_en(wr_en),
		.wr_addr(wr_addr),
		.wr_data(wr_data),
		.wr_strb(wr_strb),
		.wr_ok(wr_ok),
		.rd_addr(rd_addr),
		.rd_data(rd_data),
		.rd_ok(rd_ok)
	);

	// ----------------------------------------
	// address decode
	// ----------------------------------------
	assign wr_ok = (wr_addr == MSS_ADDR_STARTUP);
	assign rd_ok = (rd_addr == MSS_ADDR_STARTUP) || (rd_addr == MSS_ADDR_DECODED);

	always_comb begin
		rd_data = 32'h0000_0000;
		case (rd_addr)
			MSS_ADDR_STARTUP: rd_data = reg_q;
			MSS_ADDR_DECODED: rd_data = {ctrl_q.ramp_unlimited, ctrl_q.probe_runs_minus1,
				ctrl_q.align_time_ms, ctrl_q.probe_rate_hz};
			default: rd_data = 32'h0000_0000;
		endcase
	end

	// ----------------------------------------
	// byte-lane write merge
	// ----------------------------------------
	for (genvar b = 0; b < 4; b++) begin : g_lane
		assign reg_d[8*b +: 8] = (wr_en && wr_ok && wr_strb[b]) ? wr_data[8*b +: 8] : reg_q[8*b +: 8];
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			reg_q <= MSS_RESET_STARTUP;
		end else begin
			reg_q <= reg_d;
		end
	end

	// ----------------------------------------
	// field outputs
	// ----------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			fields_q <= mss_fields_t'(MSS_RESET_STARTUP);
		end else begin
			fields_q.parity <= reg_d[MSS_POS_PARITY];
			fields_q.start_method_sel <= mss_method_t'(reg_d[MSS_POS_METHOD +: 2]);
			fields_q.current_ramp_rate <= reg_d[MSS_POS_RAMP +: 4];
			fields_q.align_time <= reg_d[MSS_POS_ALIGN_TIME +: 4];
			fields_q.start_phase_current_cap <= reg_d[MSS_POS_PHASE_CAP +: 4];
			fields_q.position_probe_pulse_rate <= reg_d[MSS_POS_PULSE_RATE +: 3];
			fields_q.position_probe_current_threshold <= reg_d[MSS_POS_THRESHOLD +: 5];
			fields_q.position_probe_release_sel <= reg_d[MSS_POS_RELEASE];
			fields_q.position_probe_advance <= reg_d[MSS_POS_ADVANCE +: 2];
			fields_q.position_probe_repeat_count <= reg_d[MSS_POS_REPEAT +: 2];
			fields_q.open_loop_cap_source_sel <= reg_d[MSS_POS_CAP_SRC];
			fields_q.torque_current_rampdown_en <= reg_d[MSS_POS_RAMPDOWN];
			fields_q.active_brake_en <= reg_d[MSS_POS_BRAKE];
			fields_q.reverse_param_source_sel <= reg_d[MSS_POS_REVERSE];
		end
	end

	// ----------------------------------------
	// decoded control
	// ----------------------------------------
	mss_decode u_dec (
		.fields(mss_fields_t'(reg_d)),
		.ctrl(ctrl_d)
	);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ctrl_q <= '0;
			ctrl_q.single_align <= 1'b1;
			ctrl_q.threshold_valid <= 1'b1;
			ctrl_q.align_time_ms <= MSS_ALIGN_MS[0];
			ctrl_q.probe_rate_hz <= MSS_PROBE_HZ[0];
		end else begin
			ctrl_q <= ctrl_d;
		end
	end

endmodule : mss_startup_regs
`default_nettype wire

/* verification/mss_startup_regs_checker.sv */
// Purpose: port checker for the startup settings register
// Assumes: one clock, synchronous active-low reset
// Notes: bound from the bench top
`timescale 1ns/1ps
`default_nettype none
module mss_startup_regs_checker
	import mss_pkg::*;
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [7:0] s_awaddr,
	input wire logic s_awvalid,
	input wire logic s_awready,
	input wire logic [31:0] s_wdata,
	input wire logic [3:0] s_wstrb,
	input wire logic s_wvalid,
	input wire logic s_wready,
	input wire logic [1:0] s_bresp,
	input wire logic s_bvalid,
	input wire logic s_bready,
	input wire logic [7:0] s_araddr,
	input wire logic s_arvalid,
	input wire logic s_arready,
	input wire logic [31:0] s_rdata,
	input wire logic [1:0] s_rresp,
	input wire logic s_rvalid,
	input wire logic s_rready,
	input wire mss_fields_t fields_q,
	input wire mss_ctrl_t ctrl_q
);
	// ----------------------------------------
	// field to control relations
	// ----------------------------------------
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	property p_method;
		{ctrl_q.single_align, ctrl_q.double_align, ctrl_q.position_detect, ctrl_q.slow_cycle}
			== (4'h8 >> fields_q.start_method_sel);
	endproperty
	a_method: assert property (p_method) else $error("method decode wrong");
	property p_ramp; ctrl_q.ramp_unlimited == (fields_q.current_ramp_rate == 4'hf); endproperty
	a_ramp: assert property (p_ramp) else $error("ramp limit decode wrong");
	property p_align; ctrl_q.align_time_ms == MSS_ALIGN_MS[fields_q.align_time]; endproperty
	a_align: assert property (p_align) else $error("align time decode wrong");
	property p_rate; ctrl_q.probe_rate_hz == MSS_PROBE_HZ[fields_q.position_probe_pulse_rate]; endproperty
	a_rate: assert property (p_rate) else $error("probe rate decode wrong");
	property p_thr; ctrl_q.threshold_valid == (fields_q.position_probe_current_threshold <= 5'h11); endproperty
	a_thr: assert property (p_thr) else $error("threshold validity wrong");
	property p_adv;
		ctrl_q.advance_deg == 7'(30 * fields_q.position_probe_advance)
			&& ctrl_q.tristate_release == fields_q.position_probe_release_sel;
	endproperty
	a_adv: assert property (p_adv) else $error("release or advance wrong");
	property p_rep; ctrl_q.probe_runs_minus1 == {1'b0, fields_q.position_probe_repeat_count}; endproperty
	a_rep: assert property (p_rep) else $error("repeat decode wrong");
	property p_flags;
		{ctrl_q.use_general_cap, ctrl_q.rampdown_en, ctrl_q.brake_en, ctrl_q.use_reverse_params}
			== fields_q[3:0];
	endproperty
	a_flags: assert property (p_flags) else $error("low flag decode wrong");
	// ----------------------------------------
	// bus holding
	// ----------------------------------------
	property p_store; !$stable(fields_q) |-> $rose(s_bvalid); endproperty
	a_store: assert property (p_store) else $error("register moved outside a write");
	property p_bhold; s_bvalid && !s_bready |=> s_bvalid && $stable(s_bresp); endproperty
	a_bhold: assert property (p_bhold) else $error("write response dropped early");
	property p_rhold; s_rvalid && !s_rready |=> s_rvalid && $stable(s_rdata); endproperty
	a_rhold: assert property (p_rhold) else $error("read data dropped early");
endmodule : mss_startup_regs_checker
`default_nettype wire

/* verification/mss_startup_regs_tb_top.sv */
// Purpose: bench for the startup settings register
// Assumes: AXI4-Lite master tasks, 10 MHz clock
// Notes: expectations built from field codes
`timescale 1ns/1ps
`default_nettype none
module mss_startup_regs_tb_top;
	import mss_pkg::*;
	logic aclk = 0, aresetn = 0, awv = 0, wv = 0, bready = 0, arv = 0, rready = 0;
	logic [7:0] awaddr = 0, araddr = 0;
	logic [31:0] wdata = 0, rdata, v;
	logic [3:0] wstrb = 0;
	logic awr, wr, bvalid, arr, rvalid;
	logic [1:0] bresp, rresp, rs;
	mss_fields_t fields_q;
	mss_ctrl_t ctrl_q;
	int n_fail = 0, check_count = 0, cyc = 0;
	always #50 aclk = ~aclk;
	mss_startup_regs u_dut (.aclk(aclk), .aresetn(aresetn), .s_awaddr(awaddr), .s_awvalid(awv),
		.s_awready(awr), .s_wdata(wdata), .s_wstrb(wstrb), .s_wvalid(wv), .s_wready(wr),
		.s_bresp(bresp), .s_bvalid(bvalid), .s_bready(bready), .s_araddr(araddr), .s_arvalid(arv),
		.s_arready(arr), .s_rdata(rdata), .s_rresp(rresp), .s_rvalid(rvalid), .s_rready(rready),
		.fields_q(fields_q), .ctrl_q(ctrl_q));
	// ----------------------------------------
	// bus tasks
	// ----------------------------------------
	task automatic ck(input logic [31:0] g, input logic [31:0] e, input string m);
		check_count++;
		if (g !== e) begin
			n_fail++;
			$display("MISMATCH %0t %s got %h exp %h", $time, m, g, e);
		end
	endtask : ck
	task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
		logic ta, tw, tb;
		@(posedge aclk);
		awaddr <= a; wdata <= d; wstrb <= s; awv <= 1; wv <= 1;
		bready <= 1;
		do begin
			@(negedge aclk);
			ta = awv && awr; tw = wv && wr; tb = bvalid && bready; rs = bresp;
			@(posedge aclk);
			if (ta) awv <= 0;
			if (tw) wv <= 0;
		end while (!tb);
		bready <= 0;
	endtask : axw
	task automatic axr(input logic [7:0] a);
		logic ta, tb;
		@(posedge aclk);
		araddr <= a; arv <= 1;
		rready <= 1;
		do begin
			@(negedge aclk);
			ta = arv && arr; tb = rvalid && rready; rs = rresp; v = rdata;
			@(posedge aclk);
			if (ta) arv <= 0;
		end while (!tb);
		rready <= 0;
	endtask : axr
	task automatic tally_and_finish;
		$display("comparisons %0d mismatches %0d", check_count, n_fail);
		if (n_fail == 0 && check_count > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask : tally_and_finish
	always @(posedge aclk) begin
		cyc++;
		if (cyc == 3000) begin
			n_fail++;
			tally_and_finish();
		end
	end
	// ----------------------------------------
	// tests
	// ----------------------------------------
	initial begin
		repeat (6) @(posedge aclk);
		aresetn <= 1;
		axr(8'h84); ck(v, 32'h0, "reset image");
		axr(8'h88); ck(v, {4'h0, 14'd10, 14'd50}, "reset decode");
		$display("reset test done");
		for (int m = 0; m < 4; m++) begin
			axw(8'h84, 32'(m) << 29, 4'hf); ck(rs, MSS_RESP_OKAY, "wr resp");
			ck({ctrl_q.single_align, ctrl_q.double_align, ctrl_q.position_detect, ctrl_q.slow_cycle},
				4'h8 >> m, "method");
		end
		$display("method test done");
		axw(8'h84, {3'd2, 4'hf, 4'hf, 4'ha, 3'd7, 5'h11, 1'b1, 2'd3, 2'd3, 4'ha}, 4'hf);
		axr(8'h84); ck(v, {3'd2, 4'hf, 4'hf, 4'ha, 3'd7, 5'h11, 1'b1, 2'd3, 2'd3, 4'ha}, "image a");
		ck(fields_q, {3'd2, 4'hf, 4'hf, 4'ha, 3'd7, 5'h11, 1'b1, 2'd3, 2'd3, 4'ha}, "fields a");
		axr(8'h88); ck(v, {1'b1, 3'd3, 14'd10000, 14'd10000}, "decode a");
		ck({ctrl_q.threshold_valid, ctrl_q.tristate_release, ctrl_q.advance_deg}, {2'b11, 7'd90}, "probe a");
		ck({ctrl_q.use_general_cap, ctrl_q.rampdown_en, ctrl_q.brake_en, ctrl_q.use_reverse_params},
			4'ha, "flags a");
		axw(8'h84, {3'd0, 4'he, 4'h0, 4'h0, 3'd0, 5'h12, 1'b0, 2'd1, 2'd0, 4'h5}, 4'hf);
		axr(8'h88); ck(v, {4'h0, 14'd10, 14'd50}, "decode b");
		ck({ctrl_q.threshold_valid, ctrl_q.tristate_release, ctrl_q.advance_deg}, {2'b00, 7'd30}, "probe b");
		ck({ctrl_q.use_general_cap, ctrl_q.rampdown_en, ctrl_q.brake_en, ctrl_q.use_reverse_params},
			4'h5, "flags b");
		$display("field test done");
		axw(8'h84, 32'hffff_ffff, 4'h1);
		axr(8'h84); ck(v, {3'd0, 4'he, 4'h0, 4'h0, 3'd0, 5'h12, 1'b0, 8'hff}, "byte strobe");
		axw(8'h90, 32'h0, 4'hf); ck(rs, MSS_RESP_SLVERR, "unmapped wr");
		axr(8'h90); ck(rs, MSS_RESP_SLVERR, "unmapped rd resp");
		ck(v, 32'h0, "unmapped rd data");
		axr(8'h84); ck(v[7:0], 8'hff, "no store");
		$display("bus test done");
		tally_and_finish();
	end
endmodule : mss_startup_regs_tb_top
bind mss_startup_regs mss_startup_regs_checker u_chk (.aclk(aclk), .aresetn(aresetn), .s_awaddr(s_awaddr),
	.s_awvalid(s_awvalid), .s_awready(s_awready), .s_wdata(s_wdata), .s_wstrb(s_wstrb), .s_wvalid(s_wvalid),
	.s_wready(s_wready), .s_bresp(s_bresp), .s_bvalid(s_bvalid), .s_bready(s_bready), .s_araddr(s_araddr),
	.s_arvalid(s_arvalid), .s_arready(s_arready), .s_rdata(s_rdata), .s_rresp(s_rresp), .s_rvalid(s_rvalid),
	.s_rready(s_rready), .fields_q(fields_q), .ctrl_q(ctrl_q));
`default_nettype wire
